// ===== dv/splk_host_model.sv
/*
  Behavioural SPI mode 0 host that frames commands for the sector protect
  and lockdown block and collects read bytes.
  Assumes one caller at a time; sck stands still between frames.
*/
`timescale 1ns/1ps
module splk_host_model (
  // Serial link
  output logic      sck,
  output logic      cs_n,
  output logic      si,
  input  wire logic so
);
  logic [7:0] rx_q[$];
  event       got;

  // Chip select rises after time zero so the frame reset sees a clean edge
  initial begin
    sck  = 1'b0;
    si   = 1'b0;
    #1 cs_n = 1'b1;
  end

  // Leading gap keeps cs_n high for more than four core clocks
  task automatic xfer(input logic [7:0] tx[$], input int nrd);
    logic [7:0] b;
    #100 cs_n = 1'b0;
    foreach (tx[i]) begin
      for (int k = 7; k >= 0; k--) begin
        si = tx[i][k];
        #15 sck = 1'b1;
        #15 sck = 1'b0;
      end
    end
    for (int n = 0; n < nrd; n++) begin
      for (int k = 7; k >= 0; k--) begin
        si = ~si;
        #15 sck = 1'b1;
        b[k] = so;
        #15 sck = 1'b0;
      end
      rx_q.push_back(b);
      ->got;
    end
    #15 cs_n = 1'b1;
    si = ~si;
  endtask : xfer
endmodule : splk_host_model

// ===== dv/test_sector_protect_lockdown_cmds.sv
/*
  Self-checking bench for the sector protect and lockdown command block.
  Assumes the design package and modules and the host model are compiled first.
*/
`timescale 1ns/1ps
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin fails++; \
  $display("Error %s expected %h seen %h", nm, e, g); end end
module test_sector_protect_lockdown_cmds;
  logic        clk;
  logic        rst_n;
  logic        sck;
  logic        cs_n;
  logic        si;
  logic        so;
  logic        so_oe;
  logic        so_line;
  logic        busy;
  logic        lockdown_allowed_flag;
  logic [23:0] op_addr;
  logic        op_denied;
  logic        op_protected;
  int          fails;
  int          cmp_count;
  int          cyc;
  logic [7:0]  exp_q[$];
  logic [7:0]  pm[16];
  logic [7:0]  lk[16];
  logic [7:0]  tx[$];
  logic [7:0]  ge;
  logic [7:0]  gg;
  logic [31:0] r;

  splk_top dut_u (.clk(clk), .rst_n(rst_n), .sck(sck), .cs_n(cs_n), .si(si), .so(so),
    .so_oe(so_oe), .busy(busy), .lockdown_allowed_flag(lockdown_allowed_flag),
    .op_addr(op_addr), .op_denied(op_denied), .op_protected(op_protected));
  splk_host_model host_u (.sck(sck), .cs_n(cs_n), .si(si), .so(so_line));

  // A released output rests high through its pull-up, so a dropped enable shows up
  assign so_line = so_oe ? so : 1'b1;

  initial clk = 1'b0;
  always #10 clk = ~clk;

  always @(posedge clk) begin
    cyc++;
    if (cyc == 30000) begin
      fails++;
      end_of_test();
    end
  end

  // Read bytes are matched against notes in the order they were queued
  always @(host_u.got) begin
    while (host_u.rx_q.size() > 0) begin
      ge = exp_q.pop_front();
      gg = host_u.rx_q.pop_front();
      `CHK("map byte", ge, gg)
      `CHK("so_oe", 1'b1, so_oe)
    end
  end

  function automatic logic hit(input logic [7:0] m[16], input logic [23:0] a);
    if (a[19:16] != 4'h0) return m[a[19:16]][7];
    return (a[15:9] < 7'd8) ? m[0][7] : m[0][5];
  endfunction : hit

  task automatic cmd(input logic [7:0] op);
    tx = '{splk_pkg::OP_PREFIX_0, splk_pkg::OP_PREFIX_1, splk_pkg::OP_PREFIX_2, op};
  endtask : cmd

  task automatic read_map(input logic [7:0] op, input logic [7:0] m[16]);
    foreach (m[i]) exp_q.push_back(m[i]);
    host_u.xfer('{op, 8'h00, 8'h00, 8'h00}, 16);
    @(negedge clk);
    `CHK("so_oe", 1'b0, so_oe)
  endtask : read_map

  task automatic wait_busy(input int len);
    int n;
    n = 0;
    while (busy !== 1'b1 && n < 12) begin
      @(negedge clk);
      n++;
    end
    `CHK("busy rise", 1'b1, busy)
    n = 0;
    while (busy === 1'b1 && n < len + 30) begin
      @(negedge clk);
      n++;
    end
    `CHK("busy length", 1'b1, n >= len - 2)
    `CHK("busy fall", 1'b0, busy)
  endtask : wait_busy

  task automatic no_busy();
    logic seen;
    seen = 1'b0;
    repeat (20) begin
      @(negedge clk);
      seen = seen | busy;
    end
    `CHK("busy idle", 1'b0, seen)
  endtask : no_busy

  // Sector zero is visited on both sides of the page eight boundary
  task automatic check_addr();
    logic [23:0] a;
    for (int i = 0; i < 32; i++) begin
      a = {4'h0, 4'(i % 16), (i < 16) ? 7'd2 : 7'($urandom_range(8, 127)), 9'($urandom)};
      @(negedge clk);
      op_addr = a;
      #5;
      `CHK("op_protected", hit(pm, a), op_protected)
      `CHK("op_denied", hit(lk, a), op_denied)
    end
  endtask : check_addr

  task automatic lock_at(input logic [23:0] a, input bit takes);
    cmd(splk_pkg::OP_LOCK_SECTOR);
    tx.push_back(a[23:16]);
    tx.push_back(a[15:8]);
    tx.push_back(a[7:0]);
    host_u.xfer(tx, 0);
    if (takes) begin
      wait_busy(splk_pkg::PROG_CYCLES);
    end else begin
      no_busy();
    end
  endtask : lock_at

  task automatic end_of_test();
    $display("Comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : end_of_test

  initial begin
    rst_n = 1'b0;
    op_addr = 24'h000000;
    fails = 0;
    cmp_count = 0;
    cyc = 0;
    foreach (pm[i]) begin
      pm[i] = 8'h00;
      lk[i] = 8'h00;
    end
    r = $urandom(32'h284c);
    repeat (8) @(negedge clk);
    rst_n = 1'b1;
    repeat (4) @(negedge clk);
    `CHK("busy", 1'b0, busy)
    `CHK("flag", 1'b1, lockdown_allowed_flag)
    read_map(splk_pkg::OP_READ_PROT, pm);
    read_map(splk_pkg::OP_READ_LOCK, lk);
    check_addr();
    $display("Test reset done");
    // Seventeen bytes, the last one lands on location zero
    // The map still holds its erased reset value; one program cycle in the whole run
    cmd(splk_pkg::OP_PROG_MAP);
    for (int i = 0; i < 17; i++) begin
      r = $urandom;
      pm[i % 16] = (i % 16 == 0) ? {{2{r[1]}}, {2{r[0]}}, r[7:4]} : {8{r[0]}};
      tx.push_back(pm[i % 16]);
    end
    host_u.xfer(tx, 0);
    wait_busy(16 + splk_pkg::PROG_CYCLES);
    read_map(splk_pkg::OP_READ_PROT, pm);
    check_addr();
    $display("Test program done");
    // A wrong third prefix byte must leave the map alone
    tx = '{splk_pkg::OP_PREFIX_0, splk_pkg::OP_PREFIX_1, 8'h7e, splk_pkg::OP_PROG_MAP};
    repeat (16) tx.push_back(8'hff);
    host_u.xfer(tx, 0);
    no_busy();
    read_map(splk_pkg::OP_READ_PROT, pm);
    $display("Test bad prefix done");
    lock_at({8'h00, 7'd5, 9'($urandom)}, 1'b1);
    lk[0] = 8'hc0;
    lock_at({8'h00, 7'd200, 9'($urandom)}, 1'b1);
    lk[0] = 8'hf0;
    lock_at({8'h05, 16'($urandom)}, 1'b1);
    lk[5] = 8'hff;
    read_map(splk_pkg::OP_READ_LOCK, lk);
    check_addr();
    $display("Test lockdown done");
    // Trailing bytes after the freeze opcode are ignored
    tx = '{splk_pkg::OP_FRZ_0, splk_pkg::OP_FRZ_1, splk_pkg::OP_FRZ_2, splk_pkg::OP_FRZ_3};
    tx.push_back(8'($urandom));
    host_u.xfer(tx, 0);
    wait_busy(splk_pkg::FREEZE_CYCLES);
    `CHK("flag", 1'b0, lockdown_allowed_flag)
    lock_at({8'h09, 16'($urandom)}, 1'b0);
    read_map(splk_pkg::OP_READ_LOCK, lk);
    read_map(splk_pkg::OP_READ_PROT, pm);
    check_addr();
    `CHK("flag", 1'b0, lockdown_allowed_flag)
    $display("Test freeze done");
    end_of_test();
  end
endmodule : test_sector_protect_lockdown_cmds

// ===== logic/splk_buf.sv
/*
  Sixteen byte working buffer for the map program command.
  Write port on the link clock, read port on the core clock; the reader only
  reads after the frame has ended and the request crossed over.
*/
`timescale 1ns/1ps
module splk_buf (
  // Write side
  input  wire logic               wclk,
  input  wire splk_pkg::splk_wr_type wr,
  // Read side
  input  wire logic               rclk,
  input  wire logic [3:0]         ridx,
  output logic [7:0]              rdata
);

  logic [7:0] mem [splk_pkg::MAP_BYTES];

  always_ff @(posedge wclk) begin
    if (wr.valid) begin
      mem[wr.idx] <= wr.data;
    end
  end

  always_ff @(posedge rclk) begin
    rdata <= mem[ridx];
  end

endmodule : splk_buf

// ===== logic/splk_pkg.sv
/*
  Shared constants and types for the sector protect and lockdown command block.
  Assumes a 50 MHz system clock and an SPI mode 0 host that drives the serial clock.
*/
package splk_pkg;

  localparam logic [7:0] OP_PREFIX_0    = 8'h3d;
  localparam logic [7:0] OP_PREFIX_1    = 8'h2a;
  localparam logic [7:0] OP_PREFIX_2    = 8'h7f;
  localparam logic [7:0] OP_PROG_MAP    = 8'hfc;
  localparam logic [7:0] OP_LOCK_SECTOR = 8'h30;
  localparam logic [7:0] OP_READ_PROT   = 8'h32;
  localparam logic [7:0] OP_READ_LOCK   = 8'h35;
  localparam logic [7:0] OP_FRZ_0       = 8'h34;
  localparam logic [7:0] OP_FRZ_1       = 8'h55;
  localparam logic [7:0] OP_FRZ_2       = 8'haa;
  localparam logic [7:0] OP_FRZ_3       = 8'h40;

  localparam int         MAP_BYTES      = 16;
  localparam int         SECTOR_SHIFT   = 16;
  localparam logic [7:0] LOCK_FULL      = 8'hff;
  localparam logic [7:0] LOCK_NONE      = 8'h00;
  localparam logic [7:0] LOCK_SUB_LOW   = 8'hc0;
  localparam logic [7:0] LOCK_SUB_HIGH  = 8'h30;
  localparam logic [7:0] PROT_RESET     = 8'h00;
  localparam int         DUMMY_BYTES    = 3;
  localparam int         ADDR_BYTES     = 3;
  localparam int         BOOT_LOW_PAGES = 8;
  localparam int         PAGE_SHIFT     = 9;

  localparam int         CLK_MHZ        = 50;
  localparam int         PROG_TIME_US   = 10;
  localparam int         FREEZE_TIME_US = 10;
  localparam int         PROG_CYCLES    = PROG_TIME_US * CLK_MHZ;
  localparam int         FREEZE_CYCLES  = FREEZE_TIME_US * CLK_MHZ;

  typedef enum logic [1:0] {
    SPLK_JOB_PROG,
    SPLK_JOB_LOCK,
    SPLK_JOB_FREEZE
  } splk_job_type;

  // One finished frame handed from the link domain to the core domain
  typedef struct packed {
    splk_job_type job;
    logic [23:0]  addr;
  } splk_req_type;

  // One data byte written into the working buffer
  typedef struct packed {
    logic       valid;
    logic [3:0] idx;
    logic [7:0] data;
  } splk_wr_type;

endpackage : splk_pkg

// ===== logic/splk_sync.sv
/*
  Two flip-flop level synchroniser.
  Assumes the input toggles no faster than a few destination clock periods.
*/
`timescale 1ns/1ps
module splk_sync (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // Level
  input  wire logic din,
  output logic      dout
);

  logic meta_ff;
  logic nxt_meta;
  logic nxt_dout;

  always_comb begin
    nxt_meta = din;
    nxt_dout = meta_ff;
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      meta_ff <= 1'b0;
      dout    <= 1'b0;
    end else begin
      meta_ff <= nxt_meta;
      dout    <= nxt_dout;
    end
  end

endmodule : splk_sync

// ===== logic/splk_top.sv
/*
  Sector protection map and sector lockdown command handling.
  Serial link logic runs on sck (mode 0, MSB first); core logic runs on clk.
  Host keeps cs_n high between frames; sck stands still outside frames.
*/
// Notes on behaviour
// - Prefix then FCh, sixteen map bytes follow
// - CS rise starts timed map program, busy
// - Bytes past sixteen wrap to location zero
// - Reprogram allowed regardless of protection enable
// - Map program overwrites working buffer one
// - 32h plus three dummies streams protection map
// - Output past last map byte is undefined
// - CS high ends read, output tri-stated
// - Prefix then 30h plus address locks sector
// - CS rise starts timed lockdown, busy shown
// - Locked sectors reject program and erase forever
// - 35h plus three dummies streams lockdown map
// - Lockdown map read-only; FFh locked, 00h not
// - Sector zero lock byte C0h/30h, low zero
// - 34h 55h AAh 40h freezes; extra ignored
// - Freeze stops all later lockdown commands
// - Freeze clears lockdown allowed flag forever
// - Sector zero protect bits 7:6 and 5:4
`timescale 1ns/1ps
module splk_top (
  // Core clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // Serial link
  input  wire logic        sck,
  input  wire logic        cs_n,
  input  wire logic        si,
  output logic             so,
  output logic             so_oe,
  // Status and array guard
  output logic             busy,
  output logic             lockdown_allowed_flag,
  input  wire logic [23:0] op_addr,
  output logic             op_denied,
  output logic             op_protected
);

  typedef enum logic [2:0] {
    SPLK_ST_OP, SPLK_ST_PROG, SPLK_ST_ADDR, SPLK_ST_DUMMY,
    SPLK_ST_READ, SPLK_ST_FRZ, SPLK_ST_IGNORE
  } splk_link_type;

  typedef enum logic [1:0] {SPLK_C_IDLE, SPLK_C_COPY, SPLK_C_WAIT} splk_core_type;

  function automatic logic [3:0] sect_of(input logic [23:0] a);
    sect_of = a[splk_pkg::SECTOR_SHIFT +: 4];
  endfunction : sect_of

  function automatic logic boot_low(input logic [23:0] a);
    boot_low = (a[splk_pkg::SECTOR_SHIFT-1:splk_pkg::PAGE_SHIFT] <
                7'(splk_pkg::BOOT_LOW_PAGES));
  endfunction : boot_low

  // Link domain: reset by chip select so each frame starts clean
  splk_link_type        lst_ff,  nxt_lst;
  logic [2:0]           bit_ff,  nxt_bit;
  logic [6:0]           sh_ff,   nxt_sh;
  logic [1:0]           ocnt_ff, nxt_ocnt;
  logic [4:0]           cnt_ff,  nxt_cnt;
  logic                 rdlk_ff, nxt_rdlk;
  logic [23:0]          adr_ff,  nxt_adr;
  logic                 arm_ff,  nxt_arm;
  splk_pkg::splk_job_type ljob_ff, nxt_ljob;
  splk_pkg::splk_wr_type  wr;
  logic [7:0]           byte_in;
  logic [7:0]           osh_ff,  nxt_osh;
  logic                 frm_last;
  logic                 frame_rst;

  assign byte_in   = {sh_ff, si};
  assign frm_last  = (bit_ff == 3'h7);
  assign frame_rst = cs_n;

  // Request crossing: frame result held while cs_n high, pulse made on clk
  splk_pkg::splk_req_type req_ff, nxt_req;
  logic                 tgl_ff, nxt_tgl;

  always_comb begin
    nxt_lst  = lst_ff;
    nxt_bit  = bit_ff + 3'h1;
    nxt_sh   = byte_in[6:0];
    nxt_ocnt = ocnt_ff;
    nxt_cnt  = cnt_ff;
    nxt_rdlk = rdlk_ff;
    nxt_adr  = adr_ff;
    nxt_arm  = arm_ff;
    nxt_ljob = ljob_ff;
    wr       = '{valid: 1'b0, idx: cnt_ff[3:0], data: byte_in};
    if (frm_last) begin
      case (lst_ff)
        SPLK_ST_OP: begin
          nxt_ocnt = ocnt_ff + 2'h1;
          nxt_lst  = SPLK_ST_IGNORE;
          case (ocnt_ff)
            2'h0: begin
              if (byte_in == splk_pkg::OP_PREFIX_0 || byte_in == splk_pkg::OP_FRZ_0) begin
                nxt_lst  = SPLK_ST_OP;
                nxt_rdlk = (byte_in == splk_pkg::OP_FRZ_0);
              end else if (byte_in == splk_pkg::OP_READ_PROT ||
                           byte_in == splk_pkg::OP_READ_LOCK) begin
                nxt_lst  = SPLK_ST_DUMMY;
                nxt_rdlk = (byte_in == splk_pkg::OP_READ_LOCK);
                nxt_cnt  = 5'h0;
              end
            end
            2'h1: begin
              if (byte_in == (rdlk_ff ? splk_pkg::OP_FRZ_1 : splk_pkg::OP_PREFIX_1)) begin
                nxt_lst = SPLK_ST_OP;
              end
            end
            2'h2: begin
              if (byte_in == (rdlk_ff ? splk_pkg::OP_FRZ_2 : splk_pkg::OP_PREFIX_2)) begin
                nxt_lst = SPLK_ST_OP;
              end
            end
            default: begin
              nxt_cnt = 5'h0;
              if (rdlk_ff && byte_in == splk_pkg::OP_FRZ_3) begin
                nxt_lst  = SPLK_ST_FRZ;
                nxt_ljob = splk_pkg::SPLK_JOB_FREEZE;
                nxt_arm  = 1'b1;
              end else if (!rdlk_ff && byte_in == splk_pkg::OP_PROG_MAP) begin
                nxt_lst  = SPLK_ST_PROG;
                nxt_ljob = splk_pkg::SPLK_JOB_PROG;
              end else if (!rdlk_ff && byte_in == splk_pkg::OP_LOCK_SECTOR) begin
                nxt_lst  = SPLK_ST_ADDR;
                nxt_ljob = splk_pkg::SPLK_JOB_LOCK;
              end
            end
          endcase
        end
        SPLK_ST_PROG: begin
          wr.valid = 1'b1;
          nxt_cnt  = {1'b0, cnt_ff[3:0] + 4'h1};
          nxt_arm  = 1'b1;
        end
        SPLK_ST_ADDR: begin
          nxt_adr = {adr_ff[15:0], byte_in};
          nxt_cnt = cnt_ff + 5'h1;
          if (cnt_ff == 5'(splk_pkg::ADDR_BYTES - 1)) begin
            nxt_arm = 1'b1;
            nxt_lst = SPLK_ST_IGNORE;
          end
        end
        SPLK_ST_DUMMY: begin
          nxt_cnt = cnt_ff + 5'h1;
          if (cnt_ff == 5'(splk_pkg::DUMMY_BYTES - 1)) begin
            nxt_lst = SPLK_ST_READ;
            nxt_cnt = 5'h0;
          end
        end
        SPLK_ST_READ: begin
          nxt_cnt = (cnt_ff == 5'(splk_pkg::MAP_BYTES)) ? cnt_ff : cnt_ff + 5'h1;
        end
        SPLK_ST_FRZ: nxt_lst = SPLK_ST_FRZ;
        SPLK_ST_IGNORE: nxt_lst = SPLK_ST_IGNORE;
        default: nxt_lst = SPLK_ST_IGNORE;
      endcase
    end
  end

  always_ff @(posedge sck or posedge frame_rst) begin
    if (frame_rst) begin
      lst_ff  <= SPLK_ST_OP;
      bit_ff  <= 3'h0;
      sh_ff   <= 7'h0;
      ocnt_ff <= 2'h0;
      cnt_ff  <= 5'h0;
      rdlk_ff <= 1'b0;
      adr_ff  <= 24'h0;
      arm_ff  <= 1'b0;
      ljob_ff <= splk_pkg::SPLK_JOB_PROG;
    end else begin
      lst_ff  <= nxt_lst;
      bit_ff  <= nxt_bit;
      sh_ff   <= nxt_sh;
      ocnt_ff <= nxt_ocnt;
      cnt_ff  <= nxt_cnt;
      rdlk_ff <= nxt_rdlk;
      adr_ff  <= nxt_adr;
      arm_ff  <= nxt_arm;
      ljob_ff <= nxt_ljob;
    end
  end

  // Frame end on the rising cs_n: capture request and toggle
  // A partial trailing byte leaves bit_ff off zero and so cancels the command
  always_comb begin
    nxt_req = '{job: ljob_ff, addr: adr_ff};
    nxt_tgl = tgl_ff ^ (arm_ff && bit_ff == 3'h0);
  end

  // Cleared by rst_n so the core never sees an unknown toggle
  always_ff @(posedge cs_n or negedge rst_n) begin
    if (!rst_n) begin
      req_ff <= '{job: splk_pkg::SPLK_JOB_PROG, addr: 24'h0};
      tgl_ff <= 1'b0;
    end else begin
      req_ff <= nxt_req;
      tgl_ff <= nxt_tgl;
    end
  end

  // Core domain storage: protection map written from the working buffer port, lockdown map by lock jobs; both read by the read mux
  logic [7:0]   prot_map [splk_pkg::MAP_BYTES];
  logic [7:0]   lock_map [splk_pkg::MAP_BYTES];
  logic [7:0]   buf_q;
  logic [3:0]   copy_ff, nxt_copy;

  splk_buf u_buf (
    .wclk  (sck),
    .wr    (wr),
    .rclk  (clk),
    .ridx  (copy_ff),
    .rdata (buf_q)
  );

  // Read data: maps cross as quasi-static words, stable during any read frame taken while busy is low
  logic [7:0] rd_byte;
  always_comb begin
    rd_byte = rdlk_ff ? lock_map[cnt_ff[3:0]] : prot_map[cnt_ff[3:0]];
    if (lst_ff == SPLK_ST_READ && bit_ff == 3'h0) begin
      nxt_osh = rd_byte;
    end else begin
      nxt_osh = {osh_ff[6:0], 1'b0};
    end
  end

  always_ff @(negedge sck or posedge frame_rst) begin
    if (frame_rst) begin
      osh_ff <= 8'h0;
    end else begin
      osh_ff <= nxt_osh;
    end
  end

  assign so    = osh_ff[7];
  assign so_oe = !cs_n && lst_ff == SPLK_ST_READ;

  // Core domain
  splk_core_type cst_ff, nxt_cst;
  logic [15:0]  tmr_ff,  nxt_tmr;
  logic         frz_ff,  nxt_frz;
  logic         tgl_s, tgl_d_ff, cs_s;
  splk_pkg::splk_req_type job_ff, nxt_job;
  logic         req_evt;

  splk_sync u_tgl (.clk(clk), .rst_n(rst_n), .din(tgl_ff), .dout(tgl_s));
  splk_sync u_cs  (.clk(clk), .rst_n(rst_n), .din(cs_n),   .dout(cs_s));

  assign req_evt = (tgl_s != tgl_d_ff) && cs_s;

  always_comb begin
    nxt_cst  = cst_ff;
    nxt_tmr  = tmr_ff;
    nxt_copy = copy_ff;
    nxt_frz  = frz_ff;
    nxt_job  = job_ff;
    case (cst_ff)
      SPLK_C_IDLE: begin
        if (req_evt) begin
          nxt_job  = req_ff;
          nxt_copy = 4'h0;
          if (req_ff.job == splk_pkg::SPLK_JOB_LOCK && frz_ff) begin
            nxt_cst = SPLK_C_IDLE;
          end else if (req_ff.job == splk_pkg::SPLK_JOB_PROG) begin
            nxt_cst = SPLK_C_COPY;
          end else begin
            nxt_cst = SPLK_C_WAIT;
            nxt_tmr = (req_ff.job == splk_pkg::SPLK_JOB_FREEZE) ?
                      16'(splk_pkg::FREEZE_CYCLES) : 16'(splk_pkg::PROG_CYCLES);
          end
        end
      end
      SPLK_C_COPY: begin
        // Index holds at the last location so byte 15 stays on buf_q through the wait
        if (copy_ff == 4'hf) begin
          nxt_cst = SPLK_C_WAIT;
          nxt_tmr = 16'(splk_pkg::PROG_CYCLES);
        end else begin
          nxt_copy = copy_ff + 4'h1;
        end
      end
      SPLK_C_WAIT: begin
        nxt_tmr = tmr_ff - 16'h1;
        if (tmr_ff == 16'h1) begin
          nxt_cst = SPLK_C_IDLE;
          if (job_ff.job == splk_pkg::SPLK_JOB_FREEZE) begin
            nxt_frz = 1'b1;
          end
        end
      end
      default: nxt_cst = SPLK_C_IDLE;
    endcase
  end

  logic [3:0] lsec;
  logic [7:0] lval;
  always_comb begin
    lsec = sect_of(job_ff.addr);
    lval = splk_pkg::LOCK_FULL;
    if (lsec == 4'h0) begin
      lval = boot_low(job_ff.addr) ? splk_pkg::LOCK_SUB_LOW : splk_pkg::LOCK_SUB_HIGH;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cst_ff   <= SPLK_C_IDLE;
      tmr_ff   <= 16'h0;
      copy_ff  <= 4'h0;
      frz_ff   <= 1'b0;
      tgl_d_ff <= 1'b0;
      job_ff   <= '{job: splk_pkg::SPLK_JOB_PROG, addr: 24'h0};
      for (int i = 0; i < splk_pkg::MAP_BYTES; i++) begin
        prot_map[i] <= splk_pkg::PROT_RESET;
        lock_map[i] <= splk_pkg::LOCK_NONE;
      end
    end else begin
      cst_ff   <= nxt_cst;
      tmr_ff   <= nxt_tmr;
      copy_ff  <= nxt_copy;
      frz_ff   <= nxt_frz;
      job_ff   <= nxt_job;
      if (cs_s) begin
        tgl_d_ff <= tgl_s;
      end
      if (cst_ff == SPLK_C_COPY && copy_ff != 4'h0) begin
        prot_map[copy_ff - 4'h1] <= buf_q;
      end
      if (cst_ff == SPLK_C_WAIT && nxt_cst == SPLK_C_IDLE) begin
        if (job_ff.job == splk_pkg::SPLK_JOB_PROG) begin
          prot_map[4'hf] <= buf_q;
        end else if (job_ff.job == splk_pkg::SPLK_JOB_LOCK) begin
          lock_map[lsec] <= lock_map[lsec] | lval;
        end
      end
    end
  end

  // Array guard: locked always denies, protection map reports its bits
  always_comb begin
    op_denied    = (sect_of(op_addr) == 4'h0) ?
                   (boot_low(op_addr) ? lock_map[0][7] : lock_map[0][5]) :
                   lock_map[sect_of(op_addr)][7];
    op_protected = (sect_of(op_addr) == 4'h0) ?
                   (boot_low(op_addr) ? (&prot_map[0][7:6]) : (&prot_map[0][5:4])) :
                   prot_map[sect_of(op_addr)][7];
  end

  assign busy                  = (cst_ff != SPLK_C_IDLE);
  assign lockdown_allowed_flag = !frz_ff;

  chk_busy_hold: assert property (@(posedge clk) disable iff (!rst_n)
    (cst_ff == SPLK_C_WAIT && tmr_ff > 16'h1) |=> busy) else $error("busy dropped early");
  chk_frz_flag: assert property (@(posedge clk) disable iff (!rst_n)
    $fell(lockdown_allowed_flag) |-> $past(job_ff.job) == splk_pkg::SPLK_JOB_FREEZE)
    else $error("flag cleared without freeze");
  chk_frz_sticky: assert property (@(posedge clk) disable iff (!rst_n)
    !lockdown_allowed_flag |=> !lockdown_allowed_flag) else $error("freeze undone");
  chk_lock_sticky: assert property (@(posedge clk) disable iff (!rst_n)
    lock_map[5][7] |=> lock_map[5][7]) else $error("lock lost");
  chk_lock_low: assert property (@(posedge clk) disable iff (!rst_n)
    lock_map[0][3:0] == 4'h0) else $error("sector zero low bits set");
  chk_prog_busy: assert property (@(posedge clk) disable iff (!rst_n)
    (cst_ff == SPLK_C_IDLE && req_evt && req_ff.job == splk_pkg::SPLK_JOB_PROG)
    |=> busy [*8]) else $error("program not busy");
  chk_frozen_lock: assert property (@(posedge clk) disable iff (!rst_n)
    (cst_ff == SPLK_C_IDLE && req_evt && frz_ff && req_ff.job == splk_pkg::SPLK_JOB_LOCK)
    |=> !busy)
    else $error("lockdown taken when frozen");
  chk_guard: assert property (@(posedge clk) disable iff (!rst_n)
    (sect_of(op_addr) != 4'h0 && lock_map[sect_of(op_addr)] == splk_pkg::LOCK_FULL)
    |-> op_denied) else $error("locked sector not denied");
  cov_prog: cover property (@(posedge clk) disable iff (!rst_n)
    cst_ff == SPLK_C_COPY);
  cov_lock: cover property (@(posedge clk) disable iff (!rst_n)
    $rose(lock_map[5][7]));
  cov_frz: cover property (@(posedge clk) disable iff (!rst_n)
    $fell(lockdown_allowed_flag));

endmodule : splk_top
